// ===== src/sleep_ctrl_pkg.sv
package sleep_ctrl_pkg;
    localparam logic [7:0] OSC_CTRL_ADDR = 8'h1C;
    localparam logic [7:0] OUT_CTRL_ADDR = 8'h30;
    localparam logic [7:0] SLEEP_CTRL_ADDR = 8'h17;
    localparam logic [7:0] PSW_CTRL_ADDR = 8'h18;
    localparam int OSC_BUS_PINS_SLEEP_OFF_BIT = 2;
    localparam int OUT_CLKINT_SLEEP_KEEP_BIT = 0;
    localparam int OUT_RST_SLEEP_KEEP_BIT = 3;
    localparam int OUT_WAKE_INPUT_SLEEP_DISABLE_BIT = 5;
    localparam int SLP_REQ_BIT = 7;
    localparam int SLP_RST_BIT = 6;
    localparam int SLP_FLAG_BIT = 5;
    localparam int SLP_WAIT_LSB = 0;
    localparam int PSW_STATIC_BIT = 0;
    localparam int PSW_LOCK_BIT = 1;
    localparam int PSW_SEL_LSB = 2;
    localparam int PSW_RESET_POLARITY_BIT = 5;
    localparam logic [7:0] OSC_CTRL_RESET = 8'h00;
    localparam logic [7:0] OUT_CTRL_RESET = 8'h10;
    localparam logic [2:0] PSW_SEL_SLEEP = 3'h6;
    localparam logic [2:0] PSW_SEL_STATIC = 3'h7;
    localparam int CLK_HZ = 50_000_000;
    localparam int WAIT_PERIOD_MS = 8;
    localparam int WAIT_PERIOD_CYCLES = CLK_HZ / 1000 * WAIT_PERIOD_MS;

    typedef enum {ST_RUN, ST_WAIT, ST_SLEEP} sleep_state_t;

    typedef struct packed {
        logic alarmIrqEn;
        logic countdownIrqEn;
        logic countdownRun;
        logic extIrqEn;
        logic [4:0] watchdogPeriod;
        logic watchdogResetSteer;
    } wake_cfg_t;

    typedef struct packed {
        logic powerSwitchPin;
        logic resetOut;
        logic busPinsOff;
        logic clkintOff;
        logic wakeInputOff;
    } sleep_pins_t;
endpackage

// ===== src/period_timer.sv
`timescale 1ns/1ps
module period_timer #(
    parameter int PERIOD_CYCLES = 400000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [2:0] periods,
    output logic expired
);
    localparam int CW = $clog2(PERIOD_CYCLES + 1);
    localparam logic [CW-1:0] TOP = CW'(PERIOD_CYCLES - 1);
    logic [CW-1:0] tick_q;
    logic [3:0] left_q;
    logic running_q;
    wire tickEnd = (tick_q == TOP);

    always_ff @(posedge clk) begin
        if (rst || start) begin
            tick_q <= '0;
            left_q <= {1'b0, periods};
            running_q <= start;
        end else if (running_q) begin
            tick_q <= tickEnd ? '0 : tick_q + 1'b1;
            if (tickEnd) begin
                left_q <= left_q - 1'b1;
                if (left_q == 4'h1) begin
                    running_q <= 1'b0;
                end
            end
        end
    end
    // pulse as the last period ends
    assign expired = running_q && tickEnd && (left_q == 4'h1);
endmodule // period_timer

// ===== src/sleep_power_control_fsm.sv
`timescale 1ns/1ps
// What this block does
// - nonzero wait count stays that many periods
// - sleep flag sets on entry, software clears
// - sleep drives switch at select six, reset if both bits
// - request refused unless clock runs and armed
// - alarm, running countdown or external enables arm wake
// - watchdog interrupt mode also arms wake
// - request refused while interrupt pending
// - select seven drives pin from static bit
// - static bit set only when unlocked
// - bus pins disabled in sleep when set
// - combined interrupt is the wake condition
// - countdown expiry flag set at zero
// - interrupt in wait or sleep returns run
// - select six drives pin from sleep state
// - wait ends on timeout, enters sleep
module sleep_power_control_fsm
    import sleep_ctrl_pkg::*;
#(
    parameter int PERIOD_CYCLES = WAIT_PERIOD_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wrEn,
    input wire logic [7:0] wrAddr,
    input wire logic [7:0] wrData,
    input wire logic [7:0] rdAddr,
    output logic [7:0] rdData,
    input wire wake_cfg_t wakeCfg,
    input wire logic clockStop,
    input wire logic irqPending,
    input wire logic countdownZero,
    output logic countdownExpiredFlag,
    output sleep_pins_t pins
);
    sleep_state_t state_q, state_d;
    logic [7:0] oscCtrl_q, outCtrl_q;
    logic sleepRequest_q, sleepDrivesReset_q, sleepFlag_q;
    logic [2:0] sleepWait_q;
    logic pswStatic_q, switchLock_q, resetPolarity_q;
    logic [2:0] pswSelect_q;
    logic tfFlag_q;
    logic timerExpired;
    logic rstAsserted;

    wire wrSleep = wrEn && (wrAddr == SLEEP_CTRL_ADDR);
    wire wrPsw = wrEn && (wrAddr == PSW_CTRL_ADDR);
    wire wrOsc = wrEn && (wrAddr == OSC_CTRL_ADDR);
    wire wrOut = wrEn && (wrAddr == OUT_CTRL_ADDR);

    wire wakeSourceArmed = wakeCfg.alarmIrqEn
        || (wakeCfg.countdownIrqEn && wakeCfg.countdownRun)
        || wakeCfg.extIrqEn
        || ((wakeCfg.watchdogPeriod != 5'h00) && !wakeCfg.watchdogResetSteer);
    // pending interrupt and the combined wake signal are the same source
    wire irqCombined = irqPending;
    wire reqWrite = wrSleep && wrData[SLP_REQ_BIT];
    wire reqAccepted = reqWrite && !clockStop && wakeSourceArmed && !irqCombined;
    wire [2:0] newWait = wrData[SLP_WAIT_LSB +: 3];

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (reqAccepted) begin
                    state_d = (newWait == 3'h0) ? ST_SLEEP : ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (irqCombined) begin
                    state_d = ST_RUN;
                end else if (timerExpired) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (irqCombined) begin
                    state_d = ST_RUN;
                end
            end
        endcase
    end

    wire enterSleep = (state_d == ST_SLEEP) && (state_q != ST_SLEEP);

    period_timer #(.PERIOD_CYCLES(PERIOD_CYCLES)) waitTimer (
        .clk(clk),
        .rst(rst),
        .start(reqAccepted && (state_q == ST_RUN) && (newWait != 3'h0)),
        .periods(newWait),
        .expired(timerExpired)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sleepRequest_q <= 1'b0;
            sleepDrivesReset_q <= 1'b0;
            sleepWait_q <= 3'h0;
            sleepFlag_q <= 1'b0;
        end else begin
            if (wrSleep) begin
                sleepDrivesReset_q <= wrData[SLP_RST_BIT];
                sleepWait_q <= newWait;
            end
            if (state_d == ST_RUN) begin
                sleepRequest_q <= 1'b0;
            end else if (reqAccepted) begin
                sleepRequest_q <= 1'b1;
            end
            // set wins over a same-cycle clear
            if (enterSleep) begin
                sleepFlag_q <= 1'b1;
            end else if (wrSleep && !wrData[SLP_FLAG_BIT]) begin
                sleepFlag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pswSelect_q <= PSW_SEL_STATIC;
            pswStatic_q <= 1'b0;
            switchLock_q <= 1'b1;
            resetPolarity_q <= 1'b0;
        end else if (wrPsw) begin
            pswSelect_q <= wrData[PSW_SEL_LSB +: 3];
            switchLock_q <= wrData[PSW_LOCK_BIT];
            resetPolarity_q <= wrData[PSW_RESET_POLARITY_BIT];
            // lock is the value before this write
            if (!wrData[PSW_STATIC_BIT] || !switchLock_q) begin
                pswStatic_q <= wrData[PSW_STATIC_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            oscCtrl_q <= OSC_CTRL_RESET;
            outCtrl_q <= OUT_CTRL_RESET;
        end else begin
            if (wrOsc) begin
                oscCtrl_q <= wrData;
            end
            if (wrOut) begin
                outCtrl_q <= wrData;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tfFlag_q <= 1'b0;
        end else if (countdownZero) begin
            tfFlag_q <= 1'b1;
        end else if (wrSleep && !wrData[SLP_FLAG_BIT]) begin
            tfFlag_q <= tfFlag_q;
        end
    end
    assign countdownExpiredFlag = tfFlag_q;

    wire inSleep = (state_q == ST_SLEEP);
    wire pinSel = (pswSelect_q == PSW_SEL_SLEEP) ? inSleep
        : (pswSelect_q == PSW_SEL_STATIC) ? pswStatic_q
        : 1'b0;
    assign rstAsserted = inSleep && outCtrl_q[OUT_RST_SLEEP_KEEP_BIT] && sleepDrivesReset_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            pins <= '0;
        end else begin
            pins.powerSwitchPin <= pinSel;
            // asserted level follows reset polarity
            pins.resetOut <= rstAsserted ~^ resetPolarity_q;
            pins.busPinsOff <= inSleep && oscCtrl_q[OSC_BUS_PINS_SLEEP_OFF_BIT];
            pins.clkintOff <= inSleep && !outCtrl_q[OUT_CLKINT_SLEEP_KEEP_BIT];
            pins.wakeInputOff <= inSleep && outCtrl_q[OUT_WAKE_INPUT_SLEEP_DISABLE_BIT];
        end
    end

    wire [7:0] sleepRead = {sleepRequest_q, sleepDrivesReset_q, sleepFlag_q, 2'b00, sleepWait_q};
    wire [7:0] pswRead = {2'b00, resetPolarity_q, pswSelect_q, switchLock_q, pswStatic_q};
    assign rdData = (rdAddr == SLEEP_CTRL_ADDR) ? sleepRead
        : (rdAddr == PSW_CTRL_ADDR) ? pswRead
        : (rdAddr == OSC_CTRL_ADDR) ? oscCtrl_q
        : (rdAddr == OUT_CTRL_ADDR) ? outCtrl_q
        : 8'h00;
endmodule // sleep_power_control_fsm

// ===== dv/sleep_power_control_fsm_properties.sv
`timescale 1ns/1ps
module sleep_power_control_fsm_properties
    import sleep_ctrl_pkg::*;
#(
    parameter int PERIOD_CYCLES = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wrEn,
    input wire logic [7:0] wrAddr,
    input wire logic [7:0] wrData,
    input wire logic [7:0] rdAddr,
    input wire logic [7:0] rdData,
    input wire wake_cfg_t wakeCfg,
    input wire logic clockStop,
    input wire logic irqPending,
    input wire logic countdownZero,
    input wire logic countdownExpiredFlag,
    input wire sleep_pins_t pins
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic cdArm = wakeCfg.countdownIrqEn & wakeCfg.countdownRun;
    wire logic wdArm = (wakeCfg.watchdogPeriod != 5'h00) & !wakeCfg.watchdogResetSteer;
    wire logic wakeArmed = wakeCfg.alarmIrqEn | cdArm | wakeCfg.extIrqEn | wdArm;
    wire logic ok = !clockStop & wakeArmed & !irqPending;
    wire logic reqRd = rdAddr == SLEEP_CTRL_ADDR;
    wire logic inRun = reqRd & !rdData[7];
    wire logic offAny = pins.busPinsOff | pins.clkintOff | pins.wakeInputOff;
    // a request bit read back as 0 means the machine sits in run
    sequence s_try;
        inRun && wrEn && wrAddr == SLEEP_CTRL_ADDR && wrData[7];
    endsequence
    sequence s_run2;
        inRun ##1 inRun;
    endsequence
    AST_REFUSE: assert property (s_try ##0 !ok |=> !reqRd || !rdData[7])
        else $error("request taken while refused");
    AST_ACCEPT: assert property (s_try ##0 ok |=> !reqRd || rdData[7])
        else $error("request dropped");
    AST_SLEEP_NOW: assert property (s_try ##0 ok && wrData[2:0] == 3'h0 |=> !reqRd || rdData[5])
        else $error("no direct sleep");
    AST_WAIT_HOLD: assert property (
        s_try ##0 ok && wrData[2:0] != 3'h0 && !wrData[5] |=> !reqRd || !rdData[5])
        else $error("sleep flag during wait");
    AST_IRQ_WAKE: assert property (irqPending |-> ##2 !offAny)
        else $error("no wake on interrupt");
    AST_RUN_PINS: assert property (s_run2 |-> !offAny)
        else $error("sleep pins in run");
    AST_CDZ_SET: assert property (countdownZero |=> countdownExpiredFlag)
        else $error("countdown flag not set");
    AST_CDZ_HOLD: assert property (!countdownZero |=> $stable(countdownExpiredFlag))
        else $error("countdown flag moved");
endmodule // sleep_power_control_fsm_properties

// ===== dv/host_mcu_model.sv
`timescale 1ns/1ps
module host_mcu_model (
    input wire logic clk,
    input wire logic [7:0] rdData,
    output logic wrEn,
    output logic [7:0] wrAddr,
    output logic [7:0] wrData,
    output logic [7:0] rdAddr
);
    initial begin
        wrEn = 1'b0;
        wrAddr = 8'h00;
        wrData = 8'h00;
        rdAddr = 8'h17;
    end
    // callers keep the switch select at 6 or 7 and bit 4 of 0x30 set
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wrEn <= 1'b1;
        wrAddr <= a;
        wrData <= d;
        @(posedge clk);
        wrEn <= 1'b0;
    endtask
    // every request is read back, a 0 means it was refused
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rdAddr <= a;
        #1 d = rdData;
    endtask
endmodule // host_mcu_model

// ===== dv/sleep_power_control_fsm_tb_top.sv
`timescale 1ns/1ps
module sleep_power_control_fsm_tb_top;
    import sleep_ctrl_pkg::*;
    localparam int WAIT_CYC = 10;
    logic clk, rst, wrEn, clockStop, irqPending, countdownZero, cdFlag, s, q;
    logic [7:0] wrAddr, wrData, rdAddr, rdData, v;
    logic [7:0] ra[4] = '{8'h18, 8'h30, 8'h1c, 8'h55};
    logic [7:0] re[4] = '{8'h1e, 8'h10, 8'h00, 8'h00};
    logic [7:0] wd[4] = '{8'h1f, 8'h1d, 8'h1d, 8'h1e};
    logic [7:0] we[4] = '{8'h1e, 8'h1c, 8'h1d, 8'h1e};
    wake_cfg_t wakeCfg, c;
    sleep_pins_t pins;
    int n_fail, num_checks, cnt;
    sleep_power_control_fsm #(.PERIOD_CYCLES(WAIT_CYC)) u_dut (.clk(clk), .rst(rst),
        .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .rdAddr(rdAddr), .rdData(rdData),
        .wakeCfg(wakeCfg), .clockStop(clockStop), .irqPending(irqPending),
        .countdownZero(countdownZero), .countdownExpiredFlag(cdFlag), .pins(pins));
    host_mcu_model u_host (.clk(clk), .rdData(rdData), .wrEn(wrEn), .wrAddr(wrAddr),
        .wrData(wrData), .rdAddr(rdAddr));
    function automatic logic exp_ok(wake_cfg_t w, logic st, logic ip);
        return !st && !ip && (w.alarmIrqEn || (w.countdownIrqEn && w.countdownRun)
            || w.extIrqEn || (w.watchdogPeriod != 5'h00 && !w.watchdogResetSteer));
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wrap_up;
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        clockStop = 1'b0;
        irqPending = 1'b0;
        countdownZero = 1'b0;
        wakeCfg = '0;
        void'($urandom(65056));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            u_host.rd(ra[i], v);
            chk(v, re[i]);
        end
        for (int i = 0; i < 4; i++) begin
            u_host.wr(PSW_CTRL_ADDR, wd[i]);
            u_host.rd(PSW_CTRL_ADDR, v);
            chk(v, we[i]);
            chk(8'(pins.powerSwitchPin), 8'(we[i][0]));
        end
        chk(8'(cdFlag), 8'h00);
        countdownZero <= 1'b1;
        @(posedge clk);
        countdownZero <= 1'b0;
        repeat (3) @(posedge clk);
        chk(8'(cdFlag), 8'h01);
        // select 6, reset kept, clock pin off and bus pins off in sleep
        u_host.wr(PSW_CTRL_ADDR, 8'h1a);
        u_host.wr(OUT_CTRL_ADDR, 8'h18);
        u_host.wr(OSC_CTRL_ADDR, 8'h04);
        u_host.rd(SLEEP_CTRL_ADDR, v);
        chk(v, 8'h00);
        wakeCfg <= wake_cfg_t'(10'h200);
        u_host.wr(SLEEP_CTRL_ADDR, 8'hc2);
        cnt = 0;
        while (pins.powerSwitchPin !== 1'b1 && cnt < 100) begin
            u_host.rd(SLEEP_CTRL_ADDR, v);
            cnt++;
        end
        chk(8'(cnt >= 2 * WAIT_CYC - 1 && cnt <= 2 * WAIT_CYC + 1), 8'h01);
        if (cnt >= 100) wrap_up();
        chk(8'(pins), 8'h16);
        irqPending <= 1'b1;
        @(posedge clk);
        irqPending <= 1'b0;
        u_host.rd(SLEEP_CTRL_ADDR, v);
        chk(8'(pins), 8'h08);
        chk(v & 8'he7, 8'h62);
        for (int i = 0; i < 24; i++) begin
            c = wake_cfg_t'($urandom & (i[0] ? 32'h3ff : 32'h183));
            s = ($urandom_range(3) == 0);
            q = ($urandom_range(3) == 0);
            wakeCfg <= c;
            clockStop <= s;
            irqPending <= q;
            u_host.wr(SLEEP_CTRL_ADDR, 8'h80);
            u_host.rd(SLEEP_CTRL_ADDR, v);
            chk(8'({v[7], v[5]}), 8'({2{exp_ok(c, s, q)}}));
            irqPending <= 1'b1;
            clockStop <= 1'b0;
            u_host.wr(SLEEP_CTRL_ADDR, 8'h00);
            irqPending <= 1'b0;
            u_host.rd(SLEEP_CTRL_ADDR, v);
            chk(8'({v[7], v[5], pins.busPinsOff}), 8'h00);
        end
        wrap_up();
    end
endmodule // sleep_power_control_fsm_tb_top
bind sleep_power_control_fsm sleep_power_control_fsm_properties #(
    .PERIOD_CYCLES(PERIOD_CYCLES)) u_props (.clk(clk), .rst(rst), .wrEn(wrEn),
    .wrAddr(wrAddr), .wrData(wrData), .rdAddr(rdAddr), .rdData(rdData), .wakeCfg(wakeCfg),
    .clockStop(clockStop), .irqPending(irqPending), .countdownZero(countdownZero),
    .countdownExpiredFlag(countdownExpiredFlag), .pins(pins));
